// ===== hw/ssw_ctrl.sv
// Wire mode control, transfer counter and pin drive of the serial shift interface.
// Assumes pin inputs are asynchronous to clk_sys and the timer match is a clk_sys pulse.
//
// Design decisions made here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module ssw_ctrl (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Timer compare match
    input wire logic timer_match,
    // Serial pins
    input wire logic serial_data_in_pin,
    input wire logic serial_clock_pin,
    output ssw_pkg::ssw_pin_t data_pin,
    output ssw_pkg::ssw_pin_t clock_pin,
    output ssw_pkg::ssw_pin_t data_out_pin,
    // Interrupt requests
    output logic start_irq,
    output logic overflow_irq
);
    import ssw_pkg::*;

    logic clk_s1, clk_s2, clk_s3;
    logic dat_s1, dat_s2, dat_s3;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic start_condition_flag, overflow_flag;
    logic [CNT_W-1:0] transfer_count;
    logic start_irq_enable, overflow_irq_enable;
    logic [1:0] wm_reg;
    logic [1:0] clock_source_select;
    logic clk_sel_reg;
    logic [7:0] shift_reg;
    logic [7:0] pins_reg;
    logic do_latch_reg;
    ssw_pin_t data_pin_reg, clock_pin_reg, do_pin_reg;
    logic start_irq_reg, ovf_irq_reg;

    // Bus decode
    wire acc_fire = (avs_read | avs_write) & ~wait_reg;
    wire wr_fire = avs_write & ~wait_reg & avs_byteenable[0];
    wire [7:0] wdat = avs_writedata[7:0];
    wire sel_stat = (avs_address == ADDR_STATUS);
    wire sel_ctrl = (avs_address == ADDR_CTRL);
    wire sel_data = (avs_address == ADDR_DATA);
    wire sel_pins = (avs_address == ADDR_PINS);
    wire stat_wr = wr_fire & sel_stat;
    wire ctrl_wr = wr_fire & sel_ctrl;
    wire data_wr = wr_fire & sel_data;
    wire pins_wr = wr_fire & sel_pins;
    wire shift_stb = ctrl_wr & wdat[CT_SHIFT];
    wire tog_stb = ctrl_wr & wdat[CT_TOGGLE];

    // Mode and pin fields
    ssw_wire_mode_t wmode;
    assign wmode = ssw_wire_mode_t'(wm_reg);
    wire two_wire = wm_reg[1];
    wire ext_src = clock_source_select[1];
    wire gie = pins_reg[PN_GIE];
    wire dir_clk = pins_reg[PN_DIR_CLK];
    wire dir_dat = pins_reg[PN_DIR_DAT];
    wire dir_do = pins_reg[PN_DIR_DO];
    wire port_clk = pins_reg[PN_PORT_CLK];
    wire port_dat = pins_reg[PN_PORT_DAT];
    wire port_do = pins_reg[PN_PORT_DO];

    // Edges on synchronised pins; inputs work in every mode
    wire ck_rise = clk_s2 & ~clk_s3;
    wire ck_fall = ~clk_s2 & clk_s3;
    wire ck_any = ck_rise | ck_fall;

    // Counter and shift clocks
    wire ext_tick = clk_sel_reg ? tog_stb : ck_any;
    wire cnt_tick = (clock_source_select == CS_SOFT) ? shift_stb :
        (clock_source_select == CS_TIMER) ? timer_match : ext_tick;
    wire ext_sh = clock_source_select[0] ? ck_fall : ck_rise;
    wire sh_tick = (clock_source_select == CS_SOFT) ? shift_stb :
        (clock_source_select == CS_TIMER) ? timer_match : ext_sh;
    wire cnt_wrap = cnt_tick & ~stat_wr & (transfer_count == CNT_MAX);
    wire [CNT_W-1:0] cnt_inc = transfer_count + CNT_ONE;
    wire [CNT_W-1:0] cnt_next = stat_wr ? wdat[CNT_W-1:0] :
        cnt_tick ? cnt_inc : transfer_count;
    wire [7:0] shift_next = data_wr ? wdat :
        sh_tick ? {shift_reg[6:0], dat_s2} : shift_reg;

    // Start detector: data falls while clock stays high in two-wire modes; other modes, with ext_src set and clk_sel_reg clear, start on any clock pin edge
    wire start_det = two_wire & clk_s2 & clk_s3 & ~dat_s2 & dat_s3;
    wire edge_start = ~two_wire & ext_src & ~clk_sel_reg & ck_any;
    wire start_set = start_det | edge_start;
    // Hardware start set wins over a coinciding software clear; any status write blocks the overflow set
    wire start_next = start_set |
        (start_condition_flag & ~(stat_wr & wdat[ST_START]));
    wire ovf_next = cnt_wrap |
        (overflow_flag & ~(stat_wr & wdat[ST_OVF]));
    wire collision = shift_reg[7] ^ dat_s2;

    // Clock hold and open-collector drive
    wire ovf_hold = (wmode == WM_TWO_HOLD) & overflow_flag;
    wire hold = two_wire & (start_condition_flag | ovf_hold);
    wire clk_low = dir_clk & (~port_clk | hold);
    wire dat_low = dir_dat & (~do_latch_reg | ~port_dat);
    // Latch opens on the half opposite the sampling edge
    wire latch_open = ~ext_src | (clk_s2 == clock_source_select[0]);

    ssw_pin_t clk_drv, dat_drv, do_drv;
    assign clk_drv = two_wire ? ssw_pin_t'{1'b0, ~clk_low, 1'b0} :
        ssw_pin_t'{port_clk, ~dir_clk, ~dir_clk & port_clk};
    assign dat_drv = two_wire ? ssw_pin_t'{1'b0, ~dat_low, 1'b0} :
        ssw_pin_t'{port_dat, ~dir_dat, ~dir_dat & port_dat};
    wire do_val = (wmode == WM_THREE) ? do_latch_reg : port_do;
    assign do_drv = ssw_pin_t'{do_val, ~dir_do, ~dir_do & port_do};

    // Read mux
    wire [7:0] stat_rd = {start_condition_flag, overflow_flag, 1'b0,
        collision, transfer_count};
    wire [7:0] ctrl_rd = {start_irq_enable, overflow_irq_enable, wm_reg,
        clock_source_select, 2'h0};
    wire [7:0] rd_byte = sel_stat ? stat_rd : sel_ctrl ? ctrl_rd :
        sel_data ? shift_reg : sel_pins ? pins_reg : RST_BYTE;

    // Two-flop synchronisers; third stage only for edge detect
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            // Idle lines sit high; resetting low would fake an edge after reset
            {clk_s1, clk_s2, clk_s3} <= 3'h7;
            {dat_s1, dat_s2, dat_s3} <= 3'h7;
        end else begin
            {clk_s1, clk_s2, clk_s3} <= {serial_clock_pin, clk_s1, clk_s2};
            {dat_s1, dat_s2, dat_s3} <= {serial_data_in_pin, dat_s1, dat_s2};
        end
    end

    // One wait state; the access acts where waitrequest is low
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0;
        end else begin
            wait_reg <= ~((avs_read | avs_write) & wait_reg);
            rdata_reg <= {24'h0, rd_byte};
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            start_condition_flag <= 1'b0;
            overflow_flag <= 1'b0;
            transfer_count <= '0;
            shift_reg <= RST_BYTE;
            do_latch_reg <= 1'b0;
        end else begin
            start_condition_flag <= start_next;
            overflow_flag <= ovf_next;
            transfer_count <= cnt_next;
            shift_reg <= shift_next;
            do_latch_reg <= latch_open ? shift_reg[7] : do_latch_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            {start_irq_enable, overflow_irq_enable} <= 2'h0;
            wm_reg <= WM_OFF;
            clock_source_select <= CS_SOFT;
            clk_sel_reg <= 1'b0;
        end else if (ctrl_wr) begin
            {start_irq_enable, overflow_irq_enable} <= wdat[CT_SIE:CT_OIE];
            wm_reg <= wdat[CT_WM_HI:CT_WM_LO];
            clock_source_select <= wdat[CT_CS_HI:CT_CS_LO];
            clk_sel_reg <= wdat[CT_SHIFT];
        end
    end

    // Toggle strobe flips the clock port bit; a direct write wins
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pins_reg <= RST_BYTE;
        end else if (pins_wr) begin
            pins_reg <= wdat;
        end else if (tog_stb) begin
            pins_reg[PN_PORT_CLK] <= ~port_clk;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            data_pin_reg <= '{1'b0, 1'b1, 1'b0};
            clock_pin_reg <= '{1'b0, 1'b1, 1'b0};
            do_pin_reg <= '{1'b0, 1'b1, 1'b0};
            start_irq_reg <= 1'b0;
            ovf_irq_reg <= 1'b0;
        end else begin
            data_pin_reg <= dat_drv;
            clock_pin_reg <= clk_drv;
            do_pin_reg <= do_drv;
            start_irq_reg <= start_condition_flag & start_irq_enable & gie;
            ovf_irq_reg <= overflow_flag & overflow_irq_enable & gie;
        end
    end

    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign data_pin = data_pin_reg;
    assign clock_pin = clock_pin_reg;
    assign data_out_pin = do_pin_reg;
    assign start_irq = start_irq_reg;
    assign overflow_irq = ovf_irq_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence wrap_seq;
        ~stat_wr & cnt_tick & (transfer_count == CNT_MAX);
    endsequence
    sequence soft_strobe_seq;
        (clock_source_select == CS_SOFT) & shift_stb & ~stat_wr;
    endsequence

    overflow_set_a: assert property (wrap_seq |=> overflow_flag && transfer_count == '0)
        else $error("overflow flag not set on wrap");
    count_step_a: assert property (cnt_tick & ~stat_wr |=> transfer_count == $past(cnt_inc))
        else $error("counter did not step by one");
    count_write_a: assert property (stat_wr |=> transfer_count == $past(wdat[CNT_W-1:0]))
        else $error("counter write lost");
    soft_shift_a: assert property (soft_strobe_seq |=> $changed(transfer_count))
        else $error("shift strobe did not clock counter");
    start_keep_a: assert property (start_condition_flag & ~(stat_wr & wdat[ST_START])
        |=> start_condition_flag)
        else $error("start flag cleared without a one");
    start_hold_a: assert property (two_wire & start_condition_flag & dir_clk
        |=> clock_pin.oe_n == 1'b0)
        else $error("clock not held after start");
    off_mode_a: assert property (wmode == WM_OFF |=> clock_pin.oe_n == $past(~dir_clk))
        else $error("mode zero clock pin not ordinary port");
    start_irq_a: assert property (start_condition_flag & start_irq_enable & gie
        |=> start_irq)
        else $error("pending start interrupt not raised");
    ovf_irq_a: assert property (overflow_flag & overflow_irq_enable & gie
        |=> overflow_irq)
        else $error("pending overflow interrupt not raised");
    pullup_off_a: assert property (two_wire |=> !data_pin.pull_up && !clock_pin.pull_up)
        else $error("pull-up active in two-wire mode");
    ovf_hold_a: assert property (wmode == WM_TWO_HOLD & overflow_flag & dir_clk
        |=> clock_pin.oe_n == 1'b0)
        else $error("clock not held after overflow");
    bus_answer_a: assert property ((avs_read | avs_write) & wait_reg |=> !avs_waitrequest)
        else $error("bus answer late");
endmodule

// ===== hw/ssw_pkg.sv
// Constants, register map and pin carrier for the serial shift wire mode control.
// Assumes a 32-bit Avalon-MM bus with byte addresses; each register is one word.
package ssw_pkg;
    // Register byte offsets
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h4;
    localparam logic [3:0] ADDR_DATA = 4'h8;
    localparam logic [3:0] ADDR_PINS = 4'hC;
    // Status fields
    localparam int ST_START = 7;
    localparam int ST_OVF = 6;
    localparam int ST_COLL = 4;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_MAX = 4'hF;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    // Control fields
    localparam int CT_SIE = 7;
    localparam int CT_OIE = 6;
    localparam int CT_WM_HI = 5;
    localparam int CT_WM_LO = 4;
    localparam int CT_CS_HI = 3;
    localparam int CT_CS_LO = 2;
    localparam int CT_SHIFT = 1;
    localparam int CT_TOGGLE = 0;
    // Pin register fields
    localparam int PN_GIE = 7;
    localparam int PN_DIR_CLK = 5;
    localparam int PN_DIR_DAT = 4;
    localparam int PN_DIR_DO = 3;
    localparam int PN_PORT_CLK = 2;
    localparam int PN_PORT_DAT = 1;
    localparam int PN_PORT_DO = 0;
    // Reset values, clock source codes and wire modes
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] CS_SOFT = 2'h0;
    localparam logic [1:0] CS_TIMER = 2'h1;
    typedef enum logic [1:0] {
        WM_OFF = 2'h0,
        WM_THREE = 2'h1,
        WM_TWO = 2'h2,
        WM_TWO_HOLD = 2'h3
    } ssw_wire_mode_t;
    typedef struct packed {
        logic drv;
        logic oe_n;
        logic pull_up;
    } ssw_pin_t;
endpackage

// ===== verif/ssw_ctrl_bench.sv
// Self-checking bench for the serial shift wire mode control.
// Assumes ssw_pkg, ssw_ctrl and ssw_peer; registers reached over Avalon-MM.
`timescale 1ns/1ps
module ssw_ctrl_bench;
    import ssw_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic timer_match = 1'b0;
    logic sda;
    logic scl;
    ssw_pin_t data_pin;
    ssw_pin_t clock_pin;
    ssw_pin_t data_out_pin;
    logic start_irq;
    logic overflow_irq;
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;
    logic [15:0] expq[$];
    logic [15:0] note;
    logic [3:0] cnt;
    always #12.5 clk_sys = !clk_sys;
    ssw_ctrl u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .timer_match(timer_match),
        .serial_data_in_pin(sda), .serial_clock_pin(scl), .data_pin(data_pin),
        .clock_pin(clock_pin), .data_out_pin(data_out_pin), .start_irq(start_irq),
        .overflow_irq(overflow_irq));
    ssw_peer u_peer (.data_pin(data_pin), .clock_pin(clock_pin), .sda(sda), .scl(scl));
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    // Reads note the masked expectation; the monitor compares it
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
        input logic [7:0] m);
        @(posedge clk_sys);
        if (!wr) begin
            expq.push_back({m, d & m});
        end
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic pause(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (avs_read && avs_waitrequest === 1'b0) begin
            note = expq.pop_front();
            chk("readdata", note[7:0], avs_readdata[7:0] & note[15:8]);
        end
        // Whole run needs well under a thousand cycles
        if (cycles == 5000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        void'($urandom(82));
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        // Collision masked: the idle line reads high against a zero shift bit
        bus(1'b0, ADDR_STATUS, 8'h00, 8'hEF);
        bus(1'b0, ADDR_CTRL, 8'h00, 8'hFF);
        bus(1'b0, ADDR_PINS, 8'h00, 8'hFF);
        bus(1'b1, 4'h2, 8'hFF, 8'h00);
        bus(1'b0, 4'h2, 8'h00, 8'hFF);
        cnt = 4'($urandom_range(15, 13));
        bus(1'b1, ADDR_STATUS, {4'h0, cnt}, 8'h00);
        for (n = 0; n < 3; n++) begin
            bus(1'b1, ADDR_CTRL, 8'h02, 8'h00);
        end
        bus(1'b0, ADDR_STATUS, {4'h4, cnt + 4'h3}, 8'hCF);
        bus(1'b1, ADDR_STATUS, 8'hC0, 8'h00);
        bus(1'b1, ADDR_CTRL, 8'h04, 8'h00);
        n = $urandom_range(5, 1);
        repeat (n) begin
            timer_match <= 1'b1;
            @(posedge clk_sys);
            timer_match <= 1'b0;
            @(posedge clk_sys);
        end
        bus(1'b0, ADDR_STATUS, {4'h0, 4'(n)}, 8'h4F);
        // Timer ticks during the whole write; the written value must win
        timer_match <= 1'b1;
        bus(1'b1, ADDR_STATUS, {4'h0, 4'(n)}, 8'h00);
        timer_match <= 1'b0;
        bus(1'b0, ADDR_STATUS, {4'h0, 4'(n)}, 8'h0F);
        bus(1'b1, ADDR_CTRL, 8'h0A, 8'h00);
        bus(1'b1, ADDR_CTRL, 8'h0B, 8'h00);
        bus(1'b0, ADDR_PINS, 8'h04, 8'hFF);
        bus(1'b0, ADDR_STATUS, {4'h0, 4'(n + 1)}, 8'h0F);
        // Mode zero: clock pin edges still count, both edges
        bus(1'b1, ADDR_STATUS, 8'hC0, 8'h00);
        bus(1'b1, ADDR_CTRL, 8'h08, 8'h00);
        u_peer.edges(4);
        pause(4);
        bus(1'b0, ADDR_STATUS, 8'h84, 8'hCF);
        bus(1'b1, ADDR_STATUS, 8'hC0, 8'h00);
        // Soft source first so the output latch is open before the new MSB lands
        bus(1'b1, ADDR_CTRL, 8'hA0, 8'h00);
        bus(1'b1, ADDR_DATA, 8'hFF, 8'h00);
        bus(1'b1, ADDR_PINS, 8'hB6, 8'h00);
        pause(3);
        chk("clock_pin", 8'h02, 8'(clock_pin));
        chk("data_pin", 8'h02, 8'(data_pin));
        u_peer.start_cond();
        chk("clock_pin", 8'h00, 8'(clock_pin));
        chk("start_irq", 8'h01, 8'(start_irq));
        bus(1'b0, ADDR_STATUS, 8'h90, 8'hF0);
        bus(1'b1, ADDR_STATUS, 8'h00, 8'h00);
        bus(1'b0, ADDR_STATUS, 8'h80, 8'h80);
        u_peer.release_data();
        bus(1'b1, ADDR_STATUS, 8'h80, 8'h00);
        pause(3);
        chk("clock_pin", 8'h02, 8'(clock_pin));
        chk("start_irq", 8'h00, 8'(start_irq));
        bus(1'b1, ADDR_DATA, 8'h00, 8'h00);
        pause(3);
        chk("data_pin", 8'h00, 8'(data_pin));
        // Mode three: overflow holds the clock line
        // Data fell with the clock high: clear that start so only overflow holds
        bus(1'b1, ADDR_STATUS, 8'hCF, 8'h00);
        bus(1'b1, ADDR_CTRL, 8'h70, 8'h00);
        bus(1'b1, ADDR_CTRL, 8'h72, 8'h00);
        pause(3);
        chk("clock_pin", 8'h00, 8'(clock_pin));
        chk("overflow_irq", 8'h01, 8'(overflow_irq));
        bus(1'b1, ADDR_STATUS, 8'h40, 8'h00);
        pause(3);
        chk("clock_pin", 8'h02, 8'(clock_pin));
        chk("overflow_irq", 8'h00, 8'(overflow_irq));
        bus(1'b1, ADDR_CTRL, 8'h10, 8'h00);
        bus(1'b1, ADDR_PINS, 8'h08, 8'h00);
        bus(1'b1, ADDR_DATA, 8'h80, 8'h00);
        pause(3);
        chk("data_out_pin", 8'h04, 8'(data_out_pin));
        bus(1'b1, ADDR_PINS, 8'h01, 8'h00);
        pause(3);
        chk("data_out_pin", 8'h07, 8'(data_out_pin));
        bus(1'b1, ADDR_CTRL, 8'h00, 8'h00);
        bus(1'b1, ADDR_PINS, 8'h24, 8'h00);
        pause(3);
        chk("clock_pin", 8'h04, 8'(clock_pin));
        stop_test();
    end
endmodule

// ===== verif/ssw_peer.sv
// Serial peer on the data and clock lines, acting as a bus master.
// Assumes open-drain lines with external pull-ups; the bench calls its tasks.
`timescale 1ns/1ps
module ssw_peer
    import ssw_pkg::*;
(
    // Block pin drive
    input ssw_pkg::ssw_pin_t data_pin,
    input ssw_pkg::ssw_pin_t clock_pin,
    // Resolved line levels
    output logic sda,
    output logic scl
);
    logic sda_low = 1'b0;
    logic scl_low = 1'b0;
    // A released line floats up through the bus resistor
    assign sda = (data_pin.oe_n ? 1'b1 : data_pin.drv) & !sda_low;
    assign scl = (clock_pin.oe_n ? 1'b1 : clock_pin.drv) & !scl_low;
    // Data falls while the clock stays high
    task automatic start_cond();
        sda_low <= 1'b1;
        #200;
    endtask
    task automatic release_data();
        sda_low <= 1'b0;
        #200;
    endtask
    // One clock edge per half period of the 200 ns link clock
    task automatic edges(input int k);
        repeat (k) begin
            scl_low <= !scl_low;
            #100;
        end
    endtask
endmodule
